/* rtl/palidx_pkg.sv */
// Package for the palette index and data port block.
// Assumes an 8-bit I/O port interface with decoded addresses.
package palidx_pkg;

  localparam logic [15:0] PORT_MASK_ADDR  = 16'h03c6;
  localparam logic [15:0] PORT_STATE_ADDR = 16'h03c7;
  localparam logic [15:0] PORT_INDEX_ADDR = 16'h03c8;
  localparam logic [15:0] PORT_DATA_ADDR  = 16'h03c9;

  localparam int          ENTRIES         = 256;
  localparam int          COMP_BITS_INT   = 6;
  localparam int          COMP_BITS_EXT   = 8;

  localparam logic [7:0]  INDEX_RESET     = 8'h00;
  localparam logic [1:0]  STATE_WRITE     = 2'h0;
  localparam logic [1:0]  STATE_READ      = 2'h3;

  typedef enum logic [1:0] {PALIDX_RED, PALIDX_GREEN, PALIDX_BLUE} palidx_comp_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } palidx_io_t;

  typedef struct packed {
    logic [7:0]   index;
    logic [7:0]   save;
    palidx_comp_t comp;
    logic         read_mode;
    logic [7:0]   rdata;
  } palidx_state_t;

endpackage

/* rtl/palidx_ram.sv */
// Palette storage: entries of three colour components.
// Assumes a single-clock synchronous write, combinational read.
`timescale 1ns/1ps
module palidx_ram #(
  parameter int DEPTH = palidx_pkg::ENTRIES,
  parameter int CW    = palidx_pkg::COMP_BITS_INT
) (
  // Clock
  input  wire logic             clk,
  // Write side
  input  wire logic             we,
  input  wire logic [7:0]       waddr,
  input  wire logic [1:0]       wsel,
  input  wire logic [CW-1:0]    wdata,
  // Read side
  input  wire logic [7:0]       raddr,
  input  wire logic [1:0]       rsel,
  output logic      [CW-1:0]    rdata
);

  logic [CW-1:0] mem [DEPTH*3];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[int'(waddr) * 3 + int'(wsel)] <= wdata;
    end
  end

  assign rdata = mem[int'(raddr) * 3 + int'(rsel)];

endmodule

/* rtl/palidx_port.sv */
// Palette index, save pointer and data port sequencer.
// Assumes one-cycle I/O read/write strobes from an upstream address decoder,
// synchronous to CLK, with ports compared on all 16 address bits.
// How it works
// [R1] Index picks one of 256 palette entries
// [R2] Entry is three six-bit components
// [R3] Data accesses go red, green, blue, next
// [R4] Read-mode index written at 3C7h, write-mode at 3C8h
// [R5] Index writes load index and save pointer
// [R6] Data port addresses entry by save pointer
// [R7] Read-mode index write then increments index
// [R8] Write-mode index write does not increment
// [R9] Third byte increments save and index
// [R10] Any index write restarts at red
// [R11] Reads and writes both advance sequence
// [R12] Host keeps each three-byte group uninterrupted
// [R13] Read mode: save is index minus one
// [R14] Last index port written is recorded
// [R15] State reads 00 write-mode, 11 read-mode
// [R16] Internal palette on: strobes never asserted
// [R17] Internal off: strobes follow port accesses
// [R18] Off: 3C8h reads strobe, 3C7h reads not
// [R19] Off: index port writes assert write strobe
// [R20] Eight-bit index and save wrap around
// [R21] Reading 3C8h returns visible index
`timescale 1ns/1ps
module palidx_port #(
  parameter int CW = palidx_pkg::COMP_BITS_INT
) (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  // CPU I/O side
  input  wire palidx_pkg::palidx_io_t IO,
  output logic      [7:0]             RDATA,
  // Palette selection
  input  wire logic                   INT_PAL_EN,
  // External palette strobes
  output logic                        EXT_PALETTE_READ_STROBE_N,
  output logic                        EXT_PALETTE_WRITE_STROBE_N
);

  palidx_pkg::palidx_state_t s_q;
  palidx_pkg::palidx_state_t s_d;

  logic          hit_state;
  logic          hit_index;
  logic          hit_data;
  logic          hit_mask;
  logic          data_acc;
  logic          third;
  logic [CW-1:0] ram_rdata;
  logic [1:0]    csel;
  logic          ext_owned;
  logic          idx_wr;
  logic          rmode_wr;
  logic          wmode_wr;
  logic          data_rd;
  logic          data_wr;
  logic          ext_rd_req;
  logic          ext_wr_req;

  assign hit_state = IO.addr == palidx_pkg::PORT_STATE_ADDR; // [R4]
  assign hit_index = IO.addr == palidx_pkg::PORT_INDEX_ADDR; // [R4]
  assign hit_data  = IO.addr == palidx_pkg::PORT_DATA_ADDR;
  assign hit_mask  = IO.addr == palidx_pkg::PORT_MASK_ADDR;
  assign csel      = 2'(s_q.comp);
  // Data access only counts when the internal palette owns the port
  assign data_acc  = hit_data && (IO.rd || IO.wr) && INT_PAL_EN;
  assign third     = s_q.comp == palidx_pkg::PALIDX_BLUE;

  // Access qualifiers shared by the sequencer, the strobes and the checks
  assign ext_owned  = !INT_PAL_EN;
  assign idx_wr     = INT_PAL_EN && IO.wr && (hit_state || hit_index); // [R5]
  assign rmode_wr   = idx_wr && hit_state;                            // [R7]
  assign wmode_wr   = idx_wr && hit_index;                            // [R8]
  assign data_rd    = data_acc && IO.rd;                              // [R11]
  assign data_wr    = data_acc && IO.wr;                              // [R11]
  // The mask port lives in the external chip too, so it strobes like index and data
  assign ext_rd_req = ext_owned && IO.rd && (hit_index || hit_data || hit_mask);
  assign ext_wr_req = ext_owned && IO.wr &&
                      (hit_state || hit_index || hit_data || hit_mask);

  // Storage addressed by the save pointer, never the visible index
  palidx_ram #(
    .DEPTH (palidx_pkg::ENTRIES),
    .CW    (CW)
  ) u_ram (
    .clk   (CLK),
    .we    (data_wr),                                 // [R6]
    .waddr (s_q.save),                                // [R1]
    .wsel  (csel),
    .wdata (IO.wdata[CW-1:0]),                        // [R2]
    .raddr (s_q.save),                                // [R6]
    .rsel  (csel),
    .rdata (ram_rdata)
  );

  always_comb
  begin
    s_d = s_q;
    if (idx_wr)
    begin
      s_d.save      = IO.wdata;                       // [R5]
      s_d.index     = hit_state ? IO.wdata + 8'h01 : IO.wdata; // [R7] [R8] [R13]
      s_d.comp      = palidx_pkg::PALIDX_RED;         // [R10]
      s_d.read_mode = hit_state;                      // [R14]
    end
    else if (data_acc)
    begin
      if (third)
      begin
        // Increment keeps the read-mode offset between save and index
        s_d.save  = s_q.save + 8'h01;                 // [R9] [R20]
        s_d.index = s_q.index + 8'h01;                // [R9] [R20]
        s_d.comp  = palidx_pkg::PALIDX_RED;           // [R3]
      end
      else
      begin
        s_d.comp = s_q.comp == palidx_pkg::PALIDX_RED ?
                   palidx_pkg::PALIDX_GREEN : palidx_pkg::PALIDX_BLUE; // [R3] [R11]
      end
    end
    if (IO.rd)
    begin
      if (hit_state)
        s_d.rdata = {6'h00, s_q.read_mode ? palidx_pkg::STATE_READ
                                          : palidx_pkg::STATE_WRITE}; // [R15]
      else if (hit_index)
        s_d.rdata = s_q.index;                        // [R21]
      else if (hit_data)
        s_d.rdata = 8'(ram_rdata);
      else
        s_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_q <= '{index: palidx_pkg::INDEX_RESET, save: palidx_pkg::INDEX_RESET,
               comp: palidx_pkg::PALIDX_RED, read_mode: 1'b0, rdata: 8'h00};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;

  // External strobes track the access cycle; state port reads are always local
  assign EXT_PALETTE_READ_STROBE_N  = !ext_rd_req; // [R16] [R17] [R18]
  assign EXT_PALETTE_WRITE_STROBE_N = !ext_wr_req; // [R16] [R19]

  a_rmode_incr: assert property (@(posedge CLK) disable iff (!RST_N)
    INT_PAL_EN && IO.wr && hit_state |=> s_q.index == $past(IO.wdata) + 8'h01
      && s_q.save == $past(IO.wdata)) else $error("read-mode index write wrong"); // [R7]
  a_wmode_load: assert property (@(posedge CLK) disable iff (!RST_N)
    INT_PAL_EN && IO.wr && hit_index |=> s_q.index == $past(IO.wdata)
      && s_q.save == $past(IO.wdata)) else $error("write-mode index write wrong"); // [R8]
  a_seq_restart: assert property (@(posedge CLK) disable iff (!RST_N)
    INT_PAL_EN && IO.wr && (hit_state || hit_index) |=> s_q.comp == palidx_pkg::PALIDX_RED)
    else $error("sequence not restarted"); // [R10]
  a_third_incr: assert property (@(posedge CLK) disable iff (!RST_N)
    data_acc && third |=> s_q.save == $past(s_q.save) + 8'h01
      && s_q.index == $past(s_q.index) + 8'h01) else $error("third byte no increment"); // [R9]
  a_seq_advance: assert property (@(posedge CLK) disable iff (!RST_N)
    data_acc && !third |=> s_q.comp != $past(s_q.comp) && s_q.save == $past(s_q.save))
    else $error("sequence did not advance"); // [R11]
  a_rmode_offset: assert property (@(posedge CLK) disable iff (!RST_N)
    s_q.read_mode |-> s_q.save + 8'h01 == s_q.index) else $error("save not index-1"); // [R13]
  a_state_read: assert property (@(posedge CLK) disable iff (!RST_N)
    IO.rd && hit_state |=> RDATA == {6'h00, {2{$past(s_q.read_mode)}}})
    else $error("state readback wrong"); // [R15]
  a_strobe_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    INT_PAL_EN |-> EXT_PALETTE_READ_STROBE_N && EXT_PALETTE_WRITE_STROBE_N)
    else $error("strobe while internal palette on"); // [R16]
  a_state_nostrobe: assert property (@(posedge CLK) disable iff (!RST_N)
    IO.rd && hit_state |-> EXT_PALETTE_READ_STROBE_N) else $error("strobe on state read"); // [R18]
  a_index_read: assert property (@(posedge CLK) disable iff (!RST_N)
    IO.rd && hit_index |=> RDATA == $past(s_q.index)) else $error("index read wrong"); // [R21]

  c_full_entry: cover property (@(posedge CLK) disable iff (!RST_N)
    data_acc && third && IO.wr);
  c_rmode_write: cover property (@(posedge CLK) disable iff (!RST_N)
    INT_PAL_EN && IO.wr && hit_state);
  c_ext_write: cover property (@(posedge CLK) disable iff (!RST_N)
    !EXT_PALETTE_WRITE_STROBE_N);
  c_wrap: cover property (@(posedge CLK) disable iff (!RST_N)
    data_acc && third && s_q.save == 8'hff);
  c_ext_read: cover property (@(posedge CLK) disable iff (!RST_N)
    !EXT_PALETTE_READ_STROBE_N);

  // Strobe decode seen from the pins: external ownership first, then idle and internal-palette cases

  a_ext_rd_data: assert property ( // [R17]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned && IO.rd && hit_data
    |-> !EXT_PALETTE_READ_STROBE_N)
    else $error("no read strobe on data read");

  a_ext_wr_data: assert property ( // [R17]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned && IO.wr && hit_data
    |-> !EXT_PALETTE_WRITE_STROBE_N)
    else $error("no write strobe on data write");

  a_ext_rd_mask: assert property ( // [R17]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned && IO.rd && hit_mask
    |-> !EXT_PALETTE_READ_STROBE_N)
    else $error("no read strobe on mask read");

  a_ext_wr_mask: assert property ( // [R17]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned && IO.wr && hit_mask
    |-> !EXT_PALETTE_WRITE_STROBE_N)
    else $error("no write strobe on mask write");

  a_ext_rd_index: assert property ( // [R18]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned && IO.rd && hit_index
    |-> !EXT_PALETTE_READ_STROBE_N)
    else $error("no read strobe on index read");

  a_ext_wr_index: assert property ( // [R19]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned && IO.wr && (hit_state || hit_index)
    |-> !EXT_PALETTE_WRITE_STROBE_N)
    else $error("no write strobe on index write");

  a_idle_no_strobe: assert property ( // [R17]
    @(posedge CLK) disable iff (!RST_N)
    !IO.rd && !IO.wr
    |-> EXT_PALETTE_READ_STROBE_N && EXT_PALETTE_WRITE_STROBE_N)
    else $error("strobe without an access");

  a_int_rd_quiet: assert property ( // [R16]
    @(posedge CLK) disable iff (!RST_N)
    INT_PAL_EN && IO.rd
    |-> EXT_PALETTE_READ_STROBE_N)
    else $error("read strobe with internal palette on");

  // Sequencer state: index, save and colour position must not move while the external chip owns the ports

  a_ext_state_hold: assert property ( // [R17]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned
    |=> s_q.index == $past(s_q.index) && s_q.save == $past(s_q.save)
        && s_q.comp == $past(s_q.comp))
    else $error("local state moved while external");

  a_wmode_clear: assert property ( // [R14]
    @(posedge CLK) disable iff (!RST_N)
    wmode_wr
    |=> !s_q.read_mode)
    else $error("write-mode not recorded");

  a_rmode_set: assert property ( // [R14]
    @(posedge CLK) disable iff (!RST_N)
    rmode_wr
    |=> s_q.read_mode)
    else $error("read-mode not recorded");

  a_wmode_equal: assert property ( // [R8]
    @(posedge CLK) disable iff (!RST_N)
    wmode_wr
    |=> s_q.index == s_q.save)
    else $error("write-mode index and save differ");

  a_rmode_gap: assert property ( // [R13]
    @(posedge CLK) disable iff (!RST_N)
    rmode_wr
    |=> s_q.save + 8'h01 == s_q.index)
    else $error("read-mode gap wrong");

  a_comp_legal: assert property ( // [R3]
    @(posedge CLK) disable iff (!RST_N)
    2'(s_q.comp) != 2'h3)
    else $error("illegal colour position");

  a_red_to_green: assert property ( // [R3]
    @(posedge CLK) disable iff (!RST_N)
    data_acc && s_q.comp == palidx_pkg::PALIDX_RED
    |=> s_q.comp == palidx_pkg::PALIDX_GREEN)
    else $error("red not followed by green");

  a_green_to_blue: assert property ( // [R3]
    @(posedge CLK) disable iff (!RST_N)
    data_acc && s_q.comp == palidx_pkg::PALIDX_GREEN
    |=> s_q.comp == palidx_pkg::PALIDX_BLUE)
    else $error("green not followed by blue");

  a_blue_to_red: assert property ( // [R3]
    @(posedge CLK) disable iff (!RST_N)
    data_acc && third
    |=> s_q.comp == palidx_pkg::PALIDX_RED)
    else $error("blue not followed by red");

  a_index_hold: assert property ( // [R9]
    @(posedge CLK) disable iff (!RST_N)
    data_acc && !third
    |=> s_q.index == $past(s_q.index))
    else $error("index moved mid-entry");

  a_save_wrap: assert property ( // [R20]
    @(posedge CLK) disable iff (!RST_N)
    data_acc && third && s_q.save == 8'hff
    |=> s_q.save == 8'h00)
    else $error("save pointer did not wrap");

  // Read data path

  a_data_read: assert property ( // [R6]
    @(posedge CLK) disable iff (!RST_N)
    data_rd
    |=> RDATA == 8'($past(ram_rdata)))
    else $error("data read wrong");

  a_rdata_hold: assert property ( // [R21]
    @(posedge CLK) disable iff (!RST_N)
    !IO.rd
    |=> RDATA == $past(RDATA))
    else $error("read data changed without a read");

  a_ext_index_read: assert property ( // [R21]
    @(posedge CLK) disable iff (!RST_N)
    ext_owned && IO.rd && hit_index
    |=> RDATA == $past(s_q.index))
    else $error("index read wrong while external");

  a_state_top_zero: assert property ( // [R15]
    @(posedge CLK) disable iff (!RST_N)
    IO.rd && hit_state
    |=> RDATA[7:2] == 6'h00)
    else $error("state upper bits not zero");

  a_state_write_mode: assert property ( // [R15]
    @(posedge CLK) disable iff (!RST_N)
    IO.rd && hit_state && !s_q.read_mode
    |=> RDATA == 8'h00)
    else $error("write-mode state not 00");

endmodule

/* test/palidx_host.sv */
// Host CPU model: one-cycle I/O read and write strobes.
// Assumes the device takes a request on the rising CLK after it is driven.
`timescale 1ns/1ps
module palidx_host (
  // Clock
  input  wire logic              clk,
  // I/O side
  output palidx_pkg::palidx_io_t io,
  input  wire logic [7:0]        rdata
);
  initial io = '0;

  // Held for exactly one taking edge, then released
  task automatic xfer(input logic r, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk);
    // Released lines show inverted values so stale data cannot pass
    io <= '{rd: 1'h0, wr: 1'h0, addr: ~a, wdata: ~d};
  endtask

  // Callers keep each colour triple uninterrupted unless breaking it on purpose
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xfer(1'h0, a, d);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    xfer(1'h1, a, 8'h00);
    #1 d = rdata;
  endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the palette index and data port block.
// Assumes the host model drives every I/O request.
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] ST = palidx_pkg::PORT_STATE_ADDR;
  localparam logic [15:0] IX = palidx_pkg::PORT_INDEX_ADDR;
  localparam logic [15:0] DT = palidx_pkg::PORT_DATA_ADDR;
  logic                   clk    = 1'h0;
  logic                   rst_n  = 1'h0;
  logic                   int_en = 1'h1;
  logic [7:0]             rdata;
  logic [7:0]             v;
  logic                   rd_n;
  logic                   wr_n;
  palidx_pkg::palidx_io_t io;
  int                     n_fail     = 0;
  int                     num_checks = 0;
  int                     n_rds      = 0;
  int                     n_wrs      = 0;

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    if (rd_n === 1'h0) n_rds++;
    if (wr_n === 1'h0) n_wrs++;
  end

  palidx_host palidx_host_inst (.clk(clk), .io(io), .rdata(rdata));

  palidx_port palidx_port_inst (
    .CLK(clk), .RST_N(rst_n), .IO(io), .RDATA(rdata), .INT_PAL_EN(int_en),
    .EXT_PALETTE_READ_STROBE_N(rd_n), .EXT_PALETTE_WRITE_STROBE_N(wr_n));

  task automatic finish_test;
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    palidx_host_inst.rd(a, v);
    chk(name, exp, v);
  endtask

  // Every wait is a fixed count of edges; this bounds the whole run
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rchk("index", IX, 8'h00);
    rchk("state", ST, 8'h00);
    palidx_host_inst.wr(IX, 8'h05);
    palidx_host_inst.wr(DT, 8'h11);
    palidx_host_inst.wr(DT, 8'h22);
    palidx_host_inst.wr(DT, 8'hff);
    rchk("index", IX, 8'h06);
    palidx_host_inst.wr(ST, 8'h05);
    rchk("index", IX, 8'h06);
    rchk("state", ST, 8'h03);
    rchk("red", DT, 8'h11);
    // Mixed access: a write lands on green of the same entry
    palidx_host_inst.wr(DT, 8'h33);
    rchk("blue", DT, 8'h3f);
    rchk("index", IX, 8'h07);
    palidx_host_inst.wr(ST, 8'h05);
    rchk("red", DT, 8'h11);
    // Triple broken on purpose by an index write
    palidx_host_inst.wr(IX, 8'h05);
    rchk("red", DT, 8'h11);
    rchk("green", DT, 8'h33);
    palidx_host_inst.wr(ST, 8'hff);
    rchk("index", IX, 8'h00);
    chk("rd strobes", 8'h00, n_rds[7:0]);
    chk("wr strobes", 8'h00, n_wrs[7:0]);
    @(posedge clk);
    int_en <= 1'h0;
    palidx_host_inst.wr(palidx_pkg::PORT_MASK_ADDR, 8'h10);
    palidx_host_inst.rd(palidx_pkg::PORT_MASK_ADDR, v);
    palidx_host_inst.wr(ST, 8'h10);
    palidx_host_inst.wr(IX, 8'h10);
    palidx_host_inst.wr(DT, 8'h10);
    rchk("state", ST, 8'h03);
    palidx_host_inst.rd(IX, v);
    palidx_host_inst.rd(DT, v);
    chk("rd strobes", 8'h03, n_rds[7:0]);
    chk("wr strobes", 8'h04, n_wrs[7:0]);
    finish_test;
  end
endmodule
